// *** core/fault_rec_pkg.sv ***
package fault_rec_pkg;
   // Record geometry
   localparam int VAL_W   = 10;
   localparam int CNT_W   = 8;
   localparam int DEPTH   = 5;
   localparam int TIME_W  = 24;
   localparam int NUM_REC = 6;
   localparam int NUM_CH  = 4;

   // Record slots, zero based; display number is slot plus one
   localparam int REC_PH1  = 0;
   localparam int REC_PH2  = 1;
   localparam int REC_PH3  = 2;
   localparam int REC_LOW  = 3;
   localparam int REC_HIGH = 4;
   localparam int REC_RES  = 5;

   // Display selection codes
   localparam logic [2:0] DISP_FIRST = 3'h1;
   localparam logic [2:0] DISP_LAST  = 3'h6;
   localparam logic [2:0] SUB_COUNT  = 3'h5;

   // Values and reset contents
   localparam logic [VAL_W-1:0] VAL_RST   = 10'h000;
   localparam logic [VAL_W-1:0] PCT_FULL  = 10'h064;
   localparam logic [VAL_W-1:0] PCT_CAP   = 10'h063;
   localparam logic [CNT_W-1:0] CNT_RST   = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX   = 8'hFF;
   localparam logic [TIME_W:0]  ACC_RST   = 25'h0000000;
   localparam logic [TIME_W:0]  ACC_STEP  = 25'h0000064;

   typedef enum logic [1:0] {
      EV_IDLE  = 2'b00,
      EV_START = 2'b01,
      EV_OPER  = 2'b10
   } ev_state_e;
endpackage

// *** core/hist_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface hist_if;
   import fault_rec_pkg::*;
   logic             push;
   logic             clear;
   logic [VAL_W-1:0] din;
   logic [VAL_W-1:0] stack [DEPTH];
   modport owner (output push, output clear, output din, input stack);
   modport store (input push, input clear, input din, output stack);
endinterface
`default_nettype wire

// *** core/history_stack.sv ***
`timescale 1ns/10ps
`default_nettype none
module history_stack
   import fault_rec_pkg::*;
(
   input  wire logic clk,
   input  wire logic arst_n,
   hist_if.store     h
);
   // Newest in slot 0, oldest falls off the end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < DEPTH; i++) h.stack[i] <= VAL_RST;
      end else if (h.clear) begin
         for (int i = 0; i < DEPTH; i++) h.stack[i] <= VAL_RST;
      end else if (h.push) begin
         h.stack[0] <= h.din;
         for (int i = 1; i < DEPTH; i++) h.stack[i] <= h.stack[i-1];
      end
   end

   property p_shift;
      @(posedge clk) disable iff (!arst_n || h.clear)
      h.push |=> h.stack[0] == $past(h.din) && h.stack[DEPTH-1] == $past(h.stack[DEPTH-2]);
   endproperty
   a_shift: assert property (p_shift) else $error("History did not shift on push");

   property p_hold;
      @(posedge clk) disable iff (!arst_n || h.clear)
      !h.push |=> $stable(h.stack[0]) && $stable(h.stack[DEPTH-1]);
   endproperty
   a_hold: assert property (p_hold) else $error("History changed without push");
endmodule
`default_nettype wire

// *** core/fault_event_recorder.sv ***
// Function
// - Phase records capture on any overcurrent event
// - Capture shifts history, oldest value dropped
// - Five values: main plus four older
// - Start without operate stores start maximum
// - Operate stores current at operate instant
// - Phases two, three behave like one
// - Low-set duration percent, inverse uses calculated
// - Low-set duration captured each start, five-deep
// - Operate makes duration value 100
// - Low-set start count 0 to 255
// - High-set duration always uses set time
// - High-set start count 0 to 255
// - Residual record captures on residual events
// - Residual stores maximum, or operate value
// - Display: record digit, three value digits
// - Full reset command clears all records
`timescale 1ns/10ps
`default_nettype none
module fault_event_recorder
   import fault_rec_pkg::*;
(
   input  wire logic              CLK_SYS,
   input  wire logic              ARST_N,
   input  wire logic              OC_LOW_START,
   input  wire logic              OC_LOW_OPER,
   input  wire logic              OC_HIGH_START,
   input  wire logic              OC_HIGH_OPER,
   input  wire logic              OC_INST_START,
   input  wire logic              OC_INST_OPER,
   input  wire logic              RES_LOW_START,
   input  wire logic              RES_LOW_OPER,
   input  wire logic              RES_HIGH_START,
   input  wire logic              RES_HIGH_OPER,
   input  wire logic [VAL_W-1:0]  PHASE_ONE_CUR,
   input  wire logic [VAL_W-1:0]  PHASE_TWO_CUR,
   input  wire logic [VAL_W-1:0]  PHASE_THREE_CUR,
   input  wire logic [VAL_W-1:0]  RESIDUAL_CUR,
   input  wire logic              INVERSE_TIME_MODE,
   input  wire logic [TIME_W-1:0] LOW_SET_OPER_TIME,
   input  wire logic [TIME_W-1:0] LOW_CALC_OPER_TIME,
   input  wire logic [TIME_W-1:0] HIGH_SET_OPER_TIME,
   input  wire logic              REG_CLEAR,
   input  wire logic [2:0]        DISP_SEL,
   input  wire logic [2:0]        DISP_SUB,
   output logic      [3:0]        DISP_DIGIT,
   output logic      [VAL_W-1:0]  DISP_VALUE
);
   // Group 0 is overcurrent, group 1 residual
   logic             grp_start [2];
   logic             grp_oper  [2];
   logic             grp_push  [2];
   ev_state_e        grp_state [2];
   ev_state_e        next_grp  [2];
   logic [VAL_W-1:0] cur       [NUM_CH];
   logic [VAL_W-1:0] peak      [NUM_CH];
   // Duration stage 0 is low-set, 1 high-set
   logic              dur_start [2];
   logic              dur_oper  [2];
   logic [TIME_W-1:0] dur_ref   [2];
   ev_state_e         dur_state [2];
   logic              dur_push  [2];
   logic [VAL_W-1:0]  dur_din   [2];
   logic [TIME_W:0]   acc       [2];
   logic [VAL_W-1:0]  pct       [2];
   logic [CNT_W-1:0]  starts    [2];
   logic [VAL_W-1:0]  rec_val   [NUM_REC][DEPTH];

   hist_if h [NUM_REC] ();

   assign grp_start[0] = OC_LOW_START | OC_HIGH_START | OC_INST_START;
   assign grp_oper[0]  = OC_LOW_OPER | OC_HIGH_OPER | OC_INST_OPER;
   assign grp_start[1] = RES_LOW_START | RES_HIGH_START;
   assign grp_oper[1]  = RES_LOW_OPER | RES_HIGH_OPER;
   assign cur[0] = PHASE_ONE_CUR;
   assign cur[1] = PHASE_TWO_CUR;
   assign cur[2] = PHASE_THREE_CUR;
   assign cur[3] = RESIDUAL_CUR;
   assign dur_start[0] = OC_LOW_START;
   assign dur_oper[0]  = OC_LOW_OPER;
   assign dur_start[1] = OC_HIGH_START;
   assign dur_oper[1]  = OC_HIGH_OPER;
   assign dur_ref[0] = INVERSE_TIME_MODE ? LOW_CALC_OPER_TIME : LOW_SET_OPER_TIME;
   assign dur_ref[1] = HIGH_SET_OPER_TIME;

   // Zero operate time is treated as one cycle to keep the divider finite
   function automatic logic [TIME_W:0] ref_of(input logic [TIME_W-1:0] t);
      ref_of = (t == '0) ? {{TIME_W{1'b0}}, 1'b1} : {1'b0, t};
   endfunction

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_grp
         // Event sequencer: one history entry per start/operate episode
         always_comb begin
            next_grp[g] = grp_state[g];
            grp_push[g] = 1'b0;
            case (grp_state[g])
               EV_IDLE: begin
                  if (grp_oper[g]) begin
                     next_grp[g] = EV_OPER;
                     grp_push[g] = 1'b1;
                  end else if (grp_start[g]) begin
                     next_grp[g] = EV_START;
                  end
               end
               EV_START: begin
                  if (grp_oper[g]) begin
                     next_grp[g] = EV_OPER;
                     grp_push[g] = 1'b1;
                  end else if (!grp_start[g]) begin
                     next_grp[g] = EV_IDLE;
                     grp_push[g] = 1'b1;
                  end
               end
               // Wait for both signals to fall so the tail is not a second entry
               EV_OPER: if (!grp_start[g] && !grp_oper[g]) next_grp[g] = EV_IDLE;
               default: next_grp[g] = EV_IDLE;
            endcase
         end

         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) grp_state[g] <= EV_IDLE;
            else if (REG_CLEAR) grp_state[g] <= EV_IDLE;
            else grp_state[g] <= next_grp[g];
         end

         // Duration in percent by repeated subtraction, no divider needed
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               dur_state[g] <= EV_IDLE;
               acc[g]       <= ACC_RST;
               pct[g]       <= VAL_RST;
            end else if (REG_CLEAR) begin
               dur_state[g] <= EV_IDLE;
               acc[g]       <= ACC_RST;
               pct[g]       <= VAL_RST;
            end else begin
               case (dur_state[g])
                  EV_IDLE: begin
                     acc[g] <= ACC_RST;
                     pct[g] <= VAL_RST;
                     if (dur_oper[g]) dur_state[g] <= EV_OPER;
                     else if (dur_start[g]) dur_state[g] <= EV_START;
                  end
                  EV_START: begin
                     if (dur_oper[g]) dur_state[g] <= EV_OPER;
                     else if (!dur_start[g]) dur_state[g] <= EV_IDLE;
                     if (acc[g] + ACC_STEP >= ref_of(dur_ref[g])) begin
                        acc[g] <= acc[g] + ACC_STEP - ref_of(dur_ref[g]);
                        if (pct[g] < PCT_CAP) pct[g] <= pct[g] + 10'h001;
                     end else begin
                        acc[g] <= acc[g] + ACC_STEP;
                     end
                  end
                  EV_OPER: if (!dur_start[g] && !dur_oper[g]) dur_state[g] <= EV_IDLE;
                  default: dur_state[g] <= EV_IDLE;
               endcase
            end
         end

         // Push on operate (full time) or on a start that drops out
         always_comb begin
            dur_push[g] = 1'b0;
            dur_din[g]  = pct[g];
            if (dur_state[g] != EV_OPER && dur_oper[g]) begin
               dur_push[g] = 1'b1;
               dur_din[g]  = PCT_FULL;
            end else if (dur_state[g] == EV_START && !dur_start[g]) begin
               dur_push[g] = 1'b1;
            end
         end

         // Start counter sticks at full scale instead of wrapping
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) starts[g] <= CNT_RST;
            else if (REG_CLEAR) starts[g] <= CNT_RST;
            else if (dur_state[g] == EV_IDLE && (dur_start[g] || dur_oper[g]) && starts[g] != CNT_MAX)
               starts[g] <= starts[g] + 8'h01;
         end
      end

      // Peak tracking per channel across the start interval
      for (g = 0; g < NUM_CH; g++) begin : g_peak
         localparam int GR = (g == NUM_CH - 1) ? 1 : 0;
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) peak[g] <= VAL_RST;
            else if (grp_state[GR] != EV_START) peak[g] <= cur[g];
            else if (cur[g] > peak[g]) peak[g] <= cur[g];
         end
      end

      // Six five-deep histories, phase records identical per phase
      for (g = 0; g < NUM_REC; g++) begin : g_rec
         history_stack u_stack (
            .clk    (CLK_SYS),
            .arst_n (ARST_N),
            .h      (h[g])
         );
         assign h[g].clear = REG_CLEAR;
         for (genvar k = 0; k < DEPTH; k++) begin : g_tap
            assign rec_val[g][k] = h[g].stack[k];
         end
      end

      // Phase and residual feeds; peak includes the current cycle
      for (g = 0; g < NUM_CH; g++) begin : g_feed
         localparam int GR = (g == NUM_CH - 1) ? 1 : 0;
         localparam int RI = (g == NUM_CH - 1) ? REC_RES : g;
         assign h[RI].push = grp_push[GR];
         assign h[RI].din  = grp_oper[GR] ? cur[g]
                           : ((cur[g] > peak[g]) ? cur[g] : peak[g]);
      end
   endgenerate

   assign h[REC_LOW].push  = dur_push[0];
   assign h[REC_LOW].din   = dur_din[0];
   assign h[REC_HIGH].push = dur_push[1];
   assign h[REC_HIGH].din  = dur_din[1];

   // Display latch: record number digit plus three-digit value
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         DISP_DIGIT <= 4'h0;
         DISP_VALUE <= VAL_RST;
      end else begin
         DISP_DIGIT <= {1'b0, DISP_SEL};
         if (DISP_SEL < DISP_FIRST || DISP_SEL > DISP_LAST) DISP_VALUE <= VAL_RST;
         else if (DISP_SUB == SUB_COUNT && DISP_SEL == DISP_FIRST + 3'h3)
            DISP_VALUE <= {2'b00, starts[0]};
         else if (DISP_SUB == SUB_COUNT && DISP_SEL == DISP_FIRST + 3'h4)
            DISP_VALUE <= {2'b00, starts[1]};
         else if (DISP_SUB < SUB_COUNT)
            DISP_VALUE <= rec_val[DISP_SEL - DISP_FIRST][DISP_SUB];
         else DISP_VALUE <= VAL_RST;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N || REG_CLEAR);

   property p_oper_instant;
      grp_state[0] == EV_IDLE && grp_oper[0] |=> rec_val[REC_PH2][0] == $past(PHASE_TWO_CUR);
   endproperty
   a_oper_instant: assert property (p_oper_instant) else $error("Operate value not recorded");

   property p_phase_together;
      grp_push[0] |=> rec_val[REC_PH1][1] == $past(rec_val[REC_PH1][0])
                   && rec_val[REC_PH3][1] == $past(rec_val[REC_PH3][0]);
   endproperty
   a_phase_together: assert property (p_phase_together) else $error("Phase records not shifted");

   property p_peak_store;
      grp_state[0] == EV_START && !grp_start[0] && !grp_oper[0]
      |=> rec_val[REC_PH1][0] >= $past(peak[0]) && rec_val[REC_PH1][0] >= $past(PHASE_ONE_CUR);
   endproperty
   a_peak_store: assert property (p_peak_store) else $error("Start maximum not stored");

   property p_res_oper;
      grp_push[1] && grp_oper[1] |=> rec_val[REC_RES][0] == $past(RESIDUAL_CUR);
   endproperty
   a_res_oper: assert property (p_res_oper) else $error("Residual operate value lost");

   property p_full_time;
      dur_state[0] != EV_OPER && dur_oper[0] |=> rec_val[REC_LOW][0] == PCT_FULL;
   endproperty
   a_full_time: assert property (p_full_time) else $error("Operate duration not 100");

   property p_count_step;
      dur_state[1] == EV_IDLE && dur_start[1] && starts[1] != CNT_MAX |=> starts[1] == $past(starts[1]) + 8'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("High-set start not counted");

   property p_count_sat;
      starts[0] == CNT_MAX |=> starts[0] == CNT_MAX;
   endproperty
   a_count_sat: assert property (p_count_sat) else $error("Start counter wrapped");

   property p_one_entry;
      grp_state[0] == EV_OPER |-> !grp_push[0];
   endproperty
   a_one_entry: assert property (p_one_entry) else $error("Second entry for one event");

   property p_clear;
      @(posedge CLK_SYS) disable iff (!ARST_N)
      REG_CLEAR |=> rec_val[REC_PH1][0] == VAL_RST && starts[0] == CNT_RST && rec_val[REC_HIGH][DEPTH-1] == VAL_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("Reset command left records");

   property p_digit;
      1'b1 |=> DISP_DIGIT == {1'b0, $past(DISP_SEL)};
   endproperty
   a_digit: assert property (p_digit) else $error("Display digit wrong");

   c_start_only: cover property (grp_state[0] == EV_START && !grp_start[0] && !grp_oper[0]);
   c_operate:    cover property (grp_state[0] == EV_START ##1 grp_state[0] == EV_OPER);
   c_residual:   cover property (grp_push[1]);
   c_saturate:   cover property (starts[0] == CNT_MAX);
endmodule
`default_nettype wire

// *** testbench/stage_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// One protection stage as the recorder sees it: start and operate levels
module stage_model (
   input  wire logic clk,
   output logic      start,
   output logic      oper
);
   // Quiet stage until a test asks for an event
   initial begin
      start = 1'b0;
      oper  = 1'b0;
   end

   // Start held hold cycles, then optional operate; both drop together
   // Hold of zero with operate raises both at once (operate from idle)
   task automatic fire(input int hold, input bit op);
      @(posedge clk);
      start <= 1'b1;
      repeat (hold) @(posedge clk);
      if (op) begin
         oper <= 1'b1;
         @(posedge clk);
      end
      start <= 1'b0;
      oper  <= 1'b0;
      // Idle gap so a following start is a new event
      repeat (2) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import fault_rec_pkg::*;
   ;
   logic              clk_sys, arst_n, inv_mode, reg_clear;
   logic              lo_st, lo_op, hi_st, hi_op, in_st, in_op;
   logic              rl_st, rl_op, rh_st, rh_op;
   logic [VAL_W-1:0]  cur1, cur2, cur3, cur_res, disp_value;
   logic [TIME_W-1:0] t_low, t_calc, t_high;
   logic [2:0]        disp_sel, disp_sub;
   logic [3:0]        disp_digit;
   logic [VAL_W-1:0]  exp_rec [NUM_REC][DEPTH];
   logic [CNT_W-1:0]  cnt_low, cnt_high;
   int                n_mismatch, samples_checked;

   // Stage partners, one per start/operate pair
   stage_model u_lo (.clk(clk_sys), .start(lo_st), .oper(lo_op));
   stage_model u_hi (.clk(clk_sys), .start(hi_st), .oper(hi_op));
   stage_model u_in (.clk(clk_sys), .start(in_st), .oper(in_op));
   stage_model u_rl (.clk(clk_sys), .start(rl_st), .oper(rl_op));
   stage_model u_rh (.clk(clk_sys), .start(rh_st), .oper(rh_op));

   fault_event_recorder u_dut (
      .CLK_SYS(clk_sys), .ARST_N(arst_n),
      .OC_LOW_START(lo_st), .OC_LOW_OPER(lo_op),
      .OC_HIGH_START(hi_st), .OC_HIGH_OPER(hi_op),
      .OC_INST_START(in_st), .OC_INST_OPER(in_op),
      .RES_LOW_START(rl_st), .RES_LOW_OPER(rl_op),
      .RES_HIGH_START(rh_st), .RES_HIGH_OPER(rh_op),
      .PHASE_ONE_CUR(cur1), .PHASE_TWO_CUR(cur2),
      .PHASE_THREE_CUR(cur3), .RESIDUAL_CUR(cur_res),
      .INVERSE_TIME_MODE(inv_mode), .LOW_SET_OPER_TIME(t_low),
      .LOW_CALC_OPER_TIME(t_calc), .HIGH_SET_OPER_TIME(t_high),
      .REG_CLEAR(reg_clear), .DISP_SEL(disp_sel), .DISP_SUB(disp_sub),
      .DISP_DIGIT(disp_digit), .DISP_VALUE(disp_value));

   // 200 MHz system clock
   initial clk_sys = 1'b0;
   always #2.5 clk_sys = ~clk_sys;

   // Each phase gets its own offset so crossed channels show up
   task automatic set_cur(input logic [VAL_W-1:0] v);
      cur1    <= v;
      cur2    <= v + 10'h001;
      cur3    <= v + 10'h002;
      cur_res <= v + 10'h003;
   endtask

   // Current profile a, then b after ta cycles, then c after tb cycles
   task automatic shape(input logic [VAL_W-1:0] a, input int ta,
                        input logic [VAL_W-1:0] b, input int tb,
                        input logic [VAL_W-1:0] c);
      @(posedge clk_sys);
      set_cur(a);
      repeat (ta) @(posedge clk_sys);
      set_cur(b);
      repeat (tb) @(posedge clk_sys);
      set_cur(c);
   endtask

   // Reference history: newest at index 0, oldest falls off
   task automatic push(input int r, input logic [VAL_W-1:0] v);
      for (int i = DEPTH - 1; i > 0; i--)
         exp_rec[r][i] = exp_rec[r][i - 1];
      exp_rec[r][0] = v;
   endtask

   task automatic push_ph(input logic [VAL_W-1:0] v);
      for (int p = 0; p < 3; p++)
         push(p, v + VAL_W'(p));
   endtask

   // Percent of operate time, held below full until an operate
   function automatic logic [VAL_W-1:0] pct(input int n, input int t);
      int q;
      q = n * 100 / t;
      return VAL_W'((q > 99) ? 99 : q);
   endfunction

   // Select a record, let the registered display settle, compare
   task automatic chk(input logic [2:0] sel, input logic [2:0] sub,
                      input logic [VAL_W-1:0] ev);
      @(posedge clk_sys);
      disp_sel <= sel;
      disp_sub <= sub;
      repeat (2) @(posedge clk_sys);
      #1;
      samples_checked++;
      if (disp_value !== ev || disp_digit !== {1'b0, sel}) begin
         n_mismatch++;
         $display("MISMATCH rec %0d.%0d exp %h seen %h digit %h",
                  sel, sub, ev, disp_value, disp_digit);
      end
   endtask

   // Whole display map, counters and an invalid select
   task automatic chk_all(input string name);
      for (int r = 0; r < NUM_REC; r++)
         for (int s = 0; s < DEPTH; s++)
            chk(3'(r + 1), 3'(s), exp_rec[r][s]);
      chk(3'h4, SUB_COUNT, VAL_W'(cnt_low));
      chk(3'h5, SUB_COUNT, VAL_W'(cnt_high));
      chk(3'h7, 3'h0, VAL_RST);
      $display("test %s done", name);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence; operate times are cycle counts
   initial begin
      arst_n    = 1'b0;
      inv_mode  = 1'b0;
      reg_clear = 1'b0;
      set_cur(10'h000);
      t_low     = 24'h0003E8;
      t_calc    = 24'h0003E8;
      t_high    = 24'h0003E8;
      disp_sel  = 3'h0;
      disp_sub  = 3'h0;
      cnt_low   = CNT_RST;
      cnt_high  = CNT_RST;
      foreach (exp_rec[r, s]) exp_rec[r][s] = VAL_RST;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk_all("reset");
      // Start only: peak in mid-interval, not at either end
      fork
         u_lo.fire(505, 1'b0);
         shape(10'h020, 100, 10'h150, 100, 10'h030);
      join
      push_ph(10'h150);
      push(REC_LOW, pct(505, 1000));
      cnt_low++;
      chk_all("start max");
      // Start then operate: instant value, not the earlier peak
      fork
         u_hi.fire(6, 1'b1);
         shape(10'h200, 3, 10'h0A0, 2, 10'h0A0);
      join
      push_ph(10'h0A0);
      push(REC_HIGH, PCT_FULL);
      cnt_high++;
      chk_all("operate");
      // Six short events overflow the five-deep history
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         set_cur(10'h010 + VAL_W'(i));
         u_in.fire(2, 1'b0);
         push_ph(10'h010 + VAL_W'(i));
      end
      chk_all("history");
      // Operate straight from idle: instant value, duration full
      @(posedge clk_sys);
      set_cur(10'h0C0);
      u_lo.fire(0, 1'b1);
      push_ph(10'h0C0);
      push(REC_LOW, PCT_FULL);
      cnt_low++;
      // Inverse mode moves low-set reference only
      @(posedge clk_sys);
      inv_mode <= 1'b1;
      t_low    <= 24'h0001F4;
      t_calc   <= 24'h0007D0;
      set_cur(10'h111);
      u_lo.fire(505, 1'b0);
      u_hi.fire(505, 1'b0);
      push_ph(10'h111);
      push_ph(10'h111);
      push(REC_LOW, pct(505, 2000));
      push(REC_HIGH, pct(505, 1000));
      cnt_low++;
      cnt_high++;
      chk_all("inverse");
      // Residual stages: start maximum, then operate instant
      fork
         u_rl.fire(20, 1'b0);
         shape(10'h040, 5, 10'h180, 5, 10'h040);
      join
      push(REC_RES, 10'h183);
      fork
         u_rh.fire(4, 1'b1);
         shape(10'h300, 2, 10'h090, 2, 10'h090);
      join
      push(REC_RES, 10'h093);
      chk_all("residual");
      // Past 255 starts the low-set count must stick at full scale
      @(posedge clk_sys);
      inv_mode <= 1'b0;
      t_low    <= 24'h0003E8;
      set_cur(10'h055);
      for (int i = 0; i < 258; i++) begin
         u_lo.fire(1, 1'b0);
         push_ph(10'h055);
         push(REC_LOW, pct(1, 1000));
         if (cnt_low != CNT_MAX) cnt_low++;
      end
      chk_all("saturate");
      // Full reset command wipes records and counters
      @(posedge clk_sys);
      reg_clear <= 1'b1;
      @(posedge clk_sys);
      reg_clear <= 1'b0;
      foreach (exp_rec[r, s]) exp_rec[r][s] = VAL_RST;
      cnt_low  = CNT_RST;
      cnt_high = CNT_RST;
      chk_all("clear");
      tally_and_finish();
   end

   // Watchdog: the run needs about 3400 cycles
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_mismatch++;
      $display("MISMATCH watchdog exp done seen hang");
      tally_and_finish();
   end
endmodule
`default_nettype wire
